// file: rtl/cic_pkg.sv
package cic_pkg;
    // ==================================================
    // Bus geometry and answers
    // ==================================================
    localparam int         ADDR_W      = 12;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==================================================
    // Register indices, byte address is four times these
    // ==================================================
    localparam logic [9:0] IDX_CTRL_B0 = 10'h00b; // Control, bank 0
    localparam logic [9:0] IDX_CTRL_B1 = 10'h08b; // Control, bank 1
    localparam logic [9:0] IDX_CTRL_B2 = 10'h10b; // Control, bank 2
    localparam logic [9:0] IDX_CTRL_B3 = 10'h18b; // Control, bank 3
    localparam logic [9:0] IDX_DATA_A  = 10'h006; // Port pin readback
    localparam logic [9:0] IDX_STATUS  = 10'h040; // Sticky event status
    localparam logic [9:0] IDX_MASK    = 10'h041; // Event mask

    // ==================================================
    // Control register fields and reset value
    // ==================================================
    localparam int        GLB_EN_BIT = 7; // Global enable
    localparam int        GRP_EN_BIT = 6; // Peripheral group enable
    localparam int        TMR_IE_BIT = 5; // Timer overflow enable
    localparam int        EXT_IE_BIT = 4; // External pin enable
    localparam int        RB_IE_BIT  = 3; // Port change enable
    localparam int        TMR_IF_BIT = 2; // Timer overflow flag
    localparam int        EXT_IF_BIT = 1; // External pin flag
    localparam int        RB_IF_BIT  = 0; // Port change flag
    localparam logic [7:0] CTRL_RST  = 8'h00;

    // ==================================================
    // Event status fields
    // ==================================================
    localparam int         EV_W      = 4;
    localparam int         EV_TMR    = 0;
    localparam int         EV_EXT    = 1;
    localparam int         EV_RB     = 2;
    localparam int         EV_TAKE   = 3;
    localparam logic [3:0] EV_RST    = 4'h0;

    // ==================================================
    // Program counter vectors
    // ==================================================
    localparam int          PC_W      = 13;
    localparam logic [12:0] VEC_RESET = 13'h0000;
    localparam logic [12:0] VEC_IRQ   = 13'h0004;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        SEL_NONE, SEL_CTRL, SEL_DATA_A, SEL_STATUS, SEL_MASK
    } cic_sel_t;

    // Address decode shared by both bus directions
    function automatic cic_sel_t cic_decode(input logic [ADDR_W-1:0] addr);
        logic [9:0] idx;
        idx = addr[ADDR_W-1:2];
        if (addr[1:0] != 2'h0) begin
            return SEL_NONE;
        end
        unique case (idx)
            IDX_CTRL_B0, IDX_CTRL_B1, IDX_CTRL_B2, IDX_CTRL_B3: return SEL_CTRL;
            IDX_DATA_A: return SEL_DATA_A;
            IDX_STATUS: return SEL_STATUS;
            IDX_MASK:   return SEL_MASK;
            default:    return SEL_NONE;
        endcase
    endfunction : cic_decode
endpackage : cic_pkg

// file: rtl/cic_data_reg_a_if.sv
`timescale 1ns/100ps
// Port change detector hookup
interface cic_data_reg_a_if;
    logic [3:0] upper_data_reg_a_pins; // Compared pins
    logic       relatch;          // Capture pins now
    logic       mismatch;         // Pins differ from capture
    modport ctrl (output upper_data_reg_a_pins, output relatch, input mismatch);
    modport det  (input upper_data_reg_a_pins, input relatch, output mismatch);
endinterface : cic_data_reg_a_if

// file: rtl/cic_data_reg_a_change.sv
`timescale 1ns/100ps
module cic_data_reg_a_change
    import cic_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_srst,
    cic_data_reg_a_if.det   pb
);
    // ==================================================
    // Last captured pin values
    // ==================================================
    logic [3:0] latched; // Reference for comparison

    // Capture on a software read of the pins
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            latched <= 4'h0;
        end else if (pb.relatch) begin
            latched <= pb.upper_data_reg_a_pins;
        end
    end

    // Mismatch is high while the pins differ from the last capture
    assign pb.mismatch = (pb.upper_data_reg_a_pins != latched);
endmodule : cic_data_reg_a_change

// file: rtl/cic_core_irq_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - Flags set regardless of any enable bit
// - Control register readable, writable, three sources
// - Bit seven gates the core interrupt request, not o_irq
// - Port change flag sets while mismatch persists
// - Pin read relatches; only software clears flag
// - Reset vector zero, interrupt vector four
// - Control register mirrored at four banks
module cic_core_irq_ctrl
    import cic_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic              i_s_axi_awvalid,
    output logic                   o_s_axi_awready,
    input  wire logic [31:0]       i_s_axi_wdata,
    input  wire logic [3:0]        i_s_axi_wstrb,
    input  wire logic              i_s_axi_wvalid,
    output logic                   o_s_axi_wready,
    output logic [1:0]             o_s_axi_bresp,
    output logic                   o_s_axi_bvalid,
    input  wire logic              i_s_axi_bready,
    input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic              i_s_axi_arvalid,
    output logic                   o_s_axi_arready,
    output logic [31:0]            o_s_axi_rdata,
    output logic [1:0]             o_s_axi_rresp,
    output logic                   o_s_axi_rvalid,
    input  wire logic              i_s_axi_rready,
    // Interrupt sources
    input  wire logic              i_timer_overflow,
    input  wire logic              i_ext_irq_pin,
    input  wire logic [7:0]        i_data_reg_a_pins,
    input  wire logic              i_periph_irq_pending,
    // Core sequencer side
    output logic                   o_core_irq_req,
    input  wire logic              i_core_irq_ack,
    output logic [PC_W-1:0]        o_branch_addr,
    output logic                   o_branch_load,
    // Event interrupt
    output logic                   o_irq
);
    // ==================================================
    // Declarations
    // ==================================================
    logic [ADDR_W-1:0] aw_addr;     // Held write address
    logic              aw_held;     // Write address taken
    logic [7:0]        w_data;      // Held write byte
    logic              w_lane0;     // Low byte lane enabled
    logic              w_held;      // Write data taken
    logic              wr_fire;     // Write performed this cycle
    cic_sel_t          wr_sel;      // Write target
    cic_sel_t          rd_sel;      // Read target
    logic              rd_take;     // Read address handshake
    logic [7:0]        rd_byte;     // Read mux output
    logic [7:0]        ctrl;        // Shared control register
    logic [7:0]        next_ctrl;   // Its next value
    logic [EV_W-1:0]   status;      // Sticky events
    logic [EV_W-1:0]   next_status; // Its next value
    logic [EV_W-1:0]   mask;        // Event mask
    logic [EV_W-1:0]   events;      // This cycle's events
    logic              ext_prev;    // Pin sample last cycle
    logic              ext_rise;    // External pin rising edge
    logic              take;        // Core accepts request
    logic              ctrl_wr;     // Control written
    cic_data_reg_a_if       pb ();       // Port change link

    // ==================================================
    // Port change detector
    // ==================================================
    assign pb.upper_data_reg_a_pins = i_data_reg_a_pins[7:4];
    assign pb.relatch = rd_take && (rd_sel == SEL_DATA_A);

    cic_data_reg_a_change u_data_reg_a_change (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .pb     (pb.det)
    );

    // ==================================================
    // Write channel
    // ==================================================
    assign o_s_axi_awready = !aw_held;
    assign o_s_axi_wready  = !w_held;
    assign wr_fire         = aw_held && w_held && !o_s_axi_bvalid;
    assign wr_sel          = cic_decode(aw_addr);

    // Address capture
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (i_s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= i_s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Data capture
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            w_held  <= 1'b0;
            w_data  <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (i_s_axi_wvalid && !w_held) begin
            w_held  <= 1'b1;
            w_data  <= i_s_axi_wdata[7:0];
            w_lane0 <= i_s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    // ==================================================
    // Read channel
    // ==================================================
    assign o_s_axi_arready = !o_s_axi_rvalid;
    assign rd_take         = i_s_axi_arvalid && !o_s_axi_rvalid;
    assign rd_sel          = cic_decode(i_s_axi_araddr);

    // Read mux, upper bits read as zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (rd_sel)
            SEL_CTRL:   rd_byte = ctrl;
            SEL_DATA_A: rd_byte = i_data_reg_a_pins;
            SEL_STATUS: rd_byte = {4'h0, status};
            SEL_MASK:   rd_byte = {4'h0, mask};
            SEL_NONE:   rd_byte = 8'h00;
        endcase
    end

    // Read data and response
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= 32'h0000_0000;
            o_s_axi_rresp  <= RESP_OKAY;
        end else if (rd_take) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata  <= {24'h00_0000, rd_byte};
            o_s_axi_rresp  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

    // ==================================================
    // Source detection
    // ==================================================
    // Pin level from last cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= i_ext_irq_pin;
        end
    end

    assign ext_rise = i_ext_irq_pin && !ext_prev;
    assign ctrl_wr  = wr_fire && (wr_sel == SEL_CTRL) && w_lane0;

    // ==================================================
    // Control register
    // ==================================================
    // Hardware sets win over a software write of zero
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_wr) begin
            next_ctrl = w_data;
        end
        if (take) begin
            next_ctrl[GLB_EN_BIT] = 1'b0; // Block nesting
        end
        if (i_timer_overflow) begin
            next_ctrl[TMR_IF_BIT] = 1'b1;
        end
        if (ext_rise) begin
            next_ctrl[EXT_IF_BIT] = 1'b1;
        end
        if (pb.mismatch) begin
            next_ctrl[RB_IF_BIT] = 1'b1;
        end
    end

    // Single physical copy for all banks
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl <= CTRL_RST;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ==================================================
    // Request to the core
    // ==================================================
    always_comb begin
        o_core_irq_req = ctrl[GLB_EN_BIT] &&
            ((ctrl[TMR_IF_BIT] && ctrl[TMR_IE_BIT]) ||
             (ctrl[EXT_IF_BIT] && ctrl[EXT_IE_BIT]) ||
             (ctrl[RB_IF_BIT] && ctrl[RB_IE_BIT]) ||
             (ctrl[GRP_EN_BIT] && i_periph_irq_pending));
    end

    assign take = o_core_irq_req && i_core_irq_ack;

    // Vector to load into the program counter
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_branch_addr <= VEC_RESET;
            o_branch_load <= 1'b1;
        end else if (take) begin
            o_branch_addr <= VEC_IRQ;
            o_branch_load <= 1'b1;
        end else begin
            o_branch_load <= 1'b0;
        end
    end

    // ==================================================
    // Event status, mask and interrupt line
    // ==================================================
    always_comb begin
        events          = EV_RST;
        events[EV_TMR]  = i_timer_overflow;
        events[EV_EXT]  = ext_rise;
        events[EV_RB]   = pb.mismatch && !ctrl[RB_IF_BIT];
        events[EV_TAKE] = take;
        next_status = status;
        if (wr_fire && (wr_sel == SEL_STATUS) && w_lane0) begin
            next_status = status & ~w_data[EV_W-1:0]; // Write one clears
        end
        next_status = next_status | events; // Set wins
    end

    // Sticky status
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            status <= EV_RST;
        end else begin
            status <= next_status;
        end
    end

    // Mask register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mask <= EV_RST;
        end else if (wr_fire && (wr_sel == SEL_MASK) && w_lane0) begin
            mask <= w_data[EV_W-1:0];
        end
    end

    assign o_irq = |(status & mask);

    // ==================================================
    // Assertions
    // ==================================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_timer_flag_set:
        assert property (i_timer_overflow |=> ctrl[TMR_IF_BIT])
        else $error("timer flag not set");

    a_ext_flag_set:
        assert property ($rose(i_ext_irq_pin) |=> ctrl[EXT_IF_BIT])
        else $error("external flag not set");

    a_rb_flag_persist:
        assert property (pb.mismatch [*2] |=> ctrl[RB_IF_BIT])
        else $error("port change flag not held");

    a_rb_relatch_ends:
        assert property (pb.relatch ##1 $stable(pb.upper_data_reg_a_pins)
                         |-> !pb.mismatch)
        else $error("read did not end mismatch");

    a_rb_sw_clear_only:
        assert property (ctrl[RB_IF_BIT] && !ctrl_wr |=> ctrl[RB_IF_BIT])
        else $error("port change flag cleared by hardware");

    a_glb_gates_req:
        assert property (!ctrl[GLB_EN_BIT] |-> !o_core_irq_req)
        else $error("request without global enable");

    a_take_clears_global:
        assert property (take |=> !ctrl[GLB_EN_BIT] && !o_core_irq_req)
        else $error("global enable kept after take");

    a_periph_req:
        assert property (ctrl[GLB_EN_BIT] && ctrl[GRP_EN_BIT] && i_periph_irq_pending
                         |-> o_core_irq_req)
        else $error("peripheral request missing");

    a_irq_vector:
        assert property (take |=> o_branch_load && o_branch_addr == VEC_IRQ
                         ##1 !o_branch_load)
        else $error("interrupt vector wrong");

    a_reset_vector:
        assert property ($past(i_srst) |-> o_branch_load
                         && o_branch_addr == VEC_RESET)
        else $error("reset vector wrong");

    a_bank_write:
        assert property (ctrl_wr && !take |=> ctrl[7:3] == $past(w_data[7:3]))
        else $error("banked write lost");

    a_bresp_hold:
        assert property (o_s_axi_bvalid && !i_s_axi_bready
                         |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped");

    c_irq_taken:
        cover property (take ##1 o_branch_load);
    c_rb_flag:
        cover property (pb.mismatch ##1 pb.relatch ##2 !ctrl[RB_IF_BIT]);
    c_bank3_write:
        cover property (ctrl_wr && aw_addr[ADDR_W-1:2] == IDX_CTRL_B3);
endmodule : cic_core_irq_ctrl

// file: tb/cic_core_seq_model.sv
`timescale 1ns/100ps
// Core sequencer stand-in: acknowledges requests and records vector loads
module cic_core_seq_model
    import cic_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_srst,
    input  wire logic            i_req,   // Request level from the block
    input  wire logic [3:0]      i_delay, // Cycles before acknowledge
    input  wire logic            i_load,  // Vector load pulse
    input  wire logic [PC_W-1:0] i_addr,  // Vector offered
    output logic                 o_ack,   // One-cycle acknowledge
    output logic [7:0]           o_loads, // Loads seen since reset
    output logic [PC_W-1:0]      o_last   // Last vector loaded
);
    logic [3:0] wait_cnt; // Cycles the request has stood

    // ==================================================
    // Acknowledge
    // ==================================================
    // Prompt or slow answer, one pulse per request
    always_ff @(posedge i_clk) begin
        if (i_srst || !i_req || o_ack) begin
            wait_cnt <= 4'h0;
            o_ack    <= 1'b0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
            o_ack    <= (wait_cnt >= i_delay);
        end
    end

    // ==================================================
    // Program counter loads
    // ==================================================
    // Counts loads outside reset, the first one is the reset vector
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_loads <= 8'h00;
        end else if (i_load) begin
            o_loads <= o_loads + 8'h01;
            o_last  <= i_addr;
        end
    end
endmodule : cic_core_seq_model

// file: tb/cic_core_irq_ctrl_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module cic_core_irq_ctrl_tb_top;
    import cic_pkg::*;
    localparam logic [ADDR_W-1:0] A_DATA = {IDX_DATA_A, 2'h0};
    localparam logic [ADDR_W-1:0] A_STAT = {IDX_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] A_MASK = {IDX_MASK, 2'h0};
    localparam logic [ADDR_W-1:0] BANK_A [4] = '{{IDX_CTRL_B0, 2'h0}, {IDX_CTRL_B1, 2'h0},
                                                {IDX_CTRL_B2, 2'h0}, {IDX_CTRL_B3, 2'h0}};
    localparam logic [7:0] BANK_V [4] = '{8'h2a, 8'h54, 8'h3e, 8'h00}; // Global and port flag off
    localparam logic [7:0] TAKE_W [3] = '{8'ha4, 8'hc0, 8'h92}; // Timer, peripheral, ext pin
    localparam logic [7:0] TAKE_R [3] = '{8'h24, 8'h40, 8'h12}; // Same, global enable cleared
    // ==================================================
    // Stimulus and observation
    // ==================================================
    logic clk = 1'b0, srst = 1'b1;            // Clock, reset
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0; // Bus addresses
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata;           // Bus data
    logic [3:0] wstrb = 4'h0, delay = 4'h0;   // Strobes, partner delay
    logic awready, wready, bvalid, arready, rvalid, irq, req, ack, load;
    logic [1:0] bresp, rresp;                 // Bus answers
    logic tmr = 1'b0, ext = 1'b0, periph = 1'b0; // Event sources
    logic [7:0] pins = 8'h00, loads;          // Port pins, loads seen
    logic [PC_W-1:0] baddr, last;             // Vectors
    logic [1:0] r;                            // Response scratch
    int err_total = 0, tests_run = 0;         // Counters

    cic_core_irq_ctrl u_cic_core_irq_ctrl (.i_clk(clk), .i_srst(srst),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_timer_overflow(tmr),
        .i_ext_irq_pin(ext), .i_data_reg_a_pins(pins), .i_periph_irq_pending(periph),
        .o_core_irq_req(req), .i_core_irq_ack(ack), .o_branch_addr(baddr),
        .o_branch_load(load), .o_irq(irq));
    cic_core_seq_model u_cic_core_seq_model (.i_clk(clk), .i_srst(srst), .i_req(req),
        .i_delay(delay), .i_load(load), .i_addr(baddr), .o_ack(ack), .o_loads(loads),
        .o_last(last));

    initial begin
        forever #2 clk = ~clk;
    end

    // ==================================================
    // Bus tasks, handshakes judged from settled values
    // ==================================================
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                          output logic [1:0] rs);
        int n;
        logic ha, hw, hb;
        awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wstrb <= 4'hf;
        wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk); ha = awvalid && awready; hw = wvalid && wready;
            hb = bvalid && bready; rs = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) begin bready <= 1'b0; break; end
        end
        if (n == 50) begin err_total++; complete_run(); end
        @(posedge clk);
    endtask : axi_wr

    task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                          output logic [1:0] rs);
        int n;
        logic ha, hr;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk); ha = arvalid && arready; hr = rvalid && rready;
            d = rdata; rs = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            if (hr) begin rready <= 1'b0; break; end
        end
        if (n == 50) begin err_total++; complete_run(); end
        @(posedge clk);
    endtask : axi_rd

    // Read and compare data and response
    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] rs;
        axi_rd(a, d, rs);
        `CHK(nm, e, d)
        `CHK(nm, er, rs)
    endtask : rd_chk

    // Bounded wait for the partner to see a given load count
    task automatic wait_loads(input logic [7:0] e);
        int n;
        for (n = 0; n < 50 && loads !== e; n++) @(posedge clk);
        `CHK("load count", e, loads)
        if (loads !== e) complete_run(); // Partner never saw the load
    endtask : wait_loads

    // ==================================================
    // Main sequence
    // ==================================================
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("reset vector", VEC_RESET, last)
        `CHK("reset loads", 8'h01, loads)
        for (int i = 0; i < 4; i++) begin
            rd_chk("ctrl reset", BANK_A[i], {24'h0, CTRL_RST}, RESP_OKAY);
        end
        rd_chk("mask reset", A_MASK, 32'h0, RESP_OKAY);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            axi_wr(BANK_A[i], BANK_V[i], r);
            `CHK("bank write resp", RESP_OKAY, r)
            rd_chk("bank mirror", BANK_A[(i+1)%4], {24'h0, BANK_V[i]}, RESP_OKAY);
        end
        axi_wr(12'h7fc, 8'hff, r);
        `CHK("unmapped write", RESP_SLVERR, r)
        axi_wr(BANK_A[0] + 12'h001, 8'h7f, r);
        `CHK("misaligned write", RESP_SLVERR, r)
        rd_chk("unmapped read", 12'h7fc, 32'h0, RESP_SLVERR);
        rd_chk("ctrl untouched", BANK_A[2], 32'h0, RESP_OKAY);
        $display("test banks done");
        tmr <= 1'b1; ext <= 1'b1;
        @(posedge clk);
        tmr <= 1'b0;
        rd_chk("flags no enable", BANK_A[1], 32'h06, RESP_OKAY);
        rd_chk("status events", A_STAT, 32'h03, RESP_OKAY);
        @(negedge clk);
        `CHK("irq masked", 1'b0, irq)
        @(posedge clk);
        axi_wr(A_MASK, 8'h02, r);
        @(negedge clk);
        `CHK("irq unmasked", 1'b1, irq)
        @(posedge clk);
        axi_wr(A_STAT, 8'h02, r);
        @(negedge clk);
        `CHK("irq cleared", 1'b0, irq)
        @(posedge clk);
        rd_chk("status w1c", A_STAT, 32'h01, RESP_OKAY);
        axi_wr(A_STAT, 8'h0f, r); ext <= 1'b0;
        axi_wr(BANK_A[3], 8'h00, r);
        $display("test events done");
        pins <= 8'ha5;
        repeat (2) @(posedge clk);
        rd_chk("port flag set", BANK_A[0], 32'h01, RESP_OKAY);
        axi_wr(BANK_A[0], 8'h00, r);
        rd_chk("mismatch persists", BANK_A[0], 32'h01, RESP_OKAY);
        rd_chk("pin readback", A_DATA, 32'ha5, RESP_OKAY);
        axi_wr(BANK_A[0], 8'h00, r);
        rd_chk("port flag clear", BANK_A[0], 32'h00, RESP_OKAY);
        rd_chk("status port", A_STAT, 32'h04, RESP_OKAY);
        axi_wr(A_STAT, 8'h0f, r);
        $display("test port change done");
        delay <= 4'h3; periph <= 1'b1;
        axi_wr(BANK_A[1], 8'h24, r);
        repeat (10) @(posedge clk);
        `CHK("no take without global", 8'h01, loads)
        axi_wr(BANK_A[2], 8'h80, r);
        repeat (10) @(posedge clk);
        `CHK("no take without group", 8'h01, loads)
        for (int i = 0; i < 3; i++) begin
            axi_wr(BANK_A[i], TAKE_W[i], r);
            wait_loads(8'h02 + 8'(i));
            `CHK("irq vector", VEC_IRQ, last)
            rd_chk("global cleared", BANK_A[3], {24'h0, TAKE_R[i]}, RESP_OKAY);
            delay <= 4'h0;
        end
        rd_chk("status take", A_STAT, 32'h08, RESP_OKAY);
        $display("test takes done");
        complete_run();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule : cic_core_irq_ctrl_tb_top
